// ### bench/psu_host_model.sv
// Far-side model: sequencer idle pattern and serial link clock bursts
`default_nettype none
module psu_host_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Commands from the bench
  input wire logic i_gappy,
  input wire logic i_link_go,
  // Toward the block
  output logic o_pram_idle,
  output var logic o_link_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] slot;
  ////////////////////////////////////////////////////////////////
  // Gappy mode never leaves five idle cycles in a row, so no window opens
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) slot <= 3'h0;
    else slot <= (slot == 3'h4) ? 3'h0 : slot + 3'h1;
  end
  assign o_pram_idle = !i_gappy || (slot != 3'h4);
  ////////////////////////////////////////////////////////////////
  // Link clock runs only inside a burst of six periods and rests low between
  initial o_link_clk = 1'b0;
  always @(posedge i_link_go) begin
    repeat (6) begin
      #62.5 o_link_clk = 1'b1;
      #62.5 o_link_clk = 1'b0;
    end
  end
endmodule : psu_host_model
`default_nettype wire

// ### bench/test_psu_safeload.sv
// Self-checking bench of the parameter update block
`include "psu_map.svh"
`default_nettype none
module test_psu_safeload;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RAMP = 64;
  logic i_core_clk, i_reset_n, i_wr, i_rd, gappy, link_go, pram_idle, link_clk, o_core_halted, o_link_edge;
  logic [3:0] i_addr;
  logic [23:0] i_wdata, o_rdata, rd_val;
  logic [15:0] o_volume;
  int err_total, comparisons, cyc, edge_cnt, n;
  ////////////////////////////////////////////////////////////////
  // Block and far-side model
  psu_safeload #(.RAMP_CYCLES(RAMP), .FRAME_CYCLES(2048)) u_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pram_idle(pram_idle),
    .i_frame_start(1'b0), .i_link_clk(link_clk), .o_core_halted(o_core_halted), .o_volume(o_volume),
    .o_link_edge(o_link_edge));
  psu_host_model u_host (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_gappy(gappy), .i_link_go(link_go),
    .o_pram_idle(pram_idle), .o_link_clk(link_clk));
  ////////////////////////////////////////////////////////////////
  // Clock, watchdog and link pulse counter
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (o_link_edge === 1'b1) edge_cnt++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tally_and_finish;
    $display("mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask : rd
  task automatic ram_chk(input logic [7:0] a, input logic [21:0] exp);
    wr(`PSU_ADDR_PRAM_ADDR, {16'h0000, a});
    rd(`PSU_ADDR_PRAM_DATA);
    chk(rd_val, {2'b00, exp});
  endtask : ram_chk
  // Poll the completion flag; a frame of 2048 cycles bounds the wait
  task automatic wait_done;
    n = 0;
    do begin
      rd(`PSU_ADDR_CTRL1);
      n++;
    end while (rd_val[0] !== 1'b1 && n < 1024);
  endtask : wait_done
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults;
    logic [7:0] ad [14] = '{8'h00, 8'h01, 8'h69, 8'h6C, 8'hB5, 8'hB6, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBD, 8'hBE,
      8'hC1, 8'hC2};
    logic [21:0] ev [14] = '{`PSU_ONE, 22'h0, `PSU_ONE, 22'h0, 22'h0, 22'h0, 22'h0, 22'h0, `PSU_SPREAD_FREQ, 22'h0,
      `PSU_HALF, `PSU_HALF, `PSU_DECAY, `PSU_DECAY};
    foreach (ad[i]) ram_chk(ad[i], ev[i]);
    wr(`PSU_ADDR_PRAM_ADDR, 24'h0000BF);
    wr(`PSU_ADDR_PRAM_DATA, 24'h001388);
    ram_chk(8'hBF, 22'h000FFF);
    wr(4'h3, 24'h00FFFF);
    rd(4'h3);
    chk(rd_val, 24'h000000);
  endtask : t_defaults
  task automatic t_safeload;
    wr(`PSU_ADDR_HOLD_ADDR0, 24'h0000B9);
    wr(`PSU_ADDR_HOLD_DATA0, 24'h023456);
    wr(4'h6, 24'h000064);
    wr(4'hB, 24'h00ABCD);
    gappy <= 1'b1;
    wr(`PSU_ADDR_CTRL1, 24'h000001);
    repeat (60) @(posedge i_core_clk);
    rd(`PSU_ADDR_CTRL1);
    chk(rd_val, 24'h000000);
    gappy <= 1'b0;
    wait_done();
    chk(rd_val, 24'h000001);
    rd(`PSU_ADDR_CTRL1);
    chk(rd_val, 24'h000000);
    ram_chk(8'hB9, 22'h023456);
    ram_chk(8'h64, 22'h00ABCD);
    ram_chk(8'h00, `PSU_ONE);
    // Second round sends hold 1 alone; hold 0 is stale and must not overwrite
    wr(`PSU_ADDR_PRAM_ADDR, 24'h0000B9);
    wr(`PSU_ADDR_PRAM_DATA, 24'h000111);
    wr(4'h5, 24'h000065);
    wr(4'hA, 24'h002222);
    wr(`PSU_ADDR_CTRL1, 24'h000001);
    wait_done();
    chk(rd_val, 24'h000001);
    ram_chk(8'h65, 22'h002222);
    ram_chk(8'hB9, 22'h000111);
    ram_chk(8'h64, 22'h00ABCD);
  endtask : t_safeload
  task automatic t_shutdown;
    wr(`PSU_ADDR_CTRL2, 24'h000200);
    wr(`PSU_ADDR_CTRL0, 24'h000400);
    n = 0;
    while (o_core_halted !== 1'b1 && n < 400) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    chk(24'(n >= RAMP * 2 / 3 && n <= RAMP * 4 / 3 + 4), 24'h000001);
    chk({8'h00, o_volume}, 24'h000000);
    rd(`PSU_ADDR_CTRL1);
    chk(rd_val, 24'h000002);
    wr(`PSU_ADDR_CTRL0, 24'h000000);
    n = 0;
    while (o_volume !== 16'hFFFF && n < 400) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    chk(24'(n >= RAMP * 2 / 3 && n <= RAMP * 4 / 3 + 4), 24'h000001);
    chk({23'h0, o_core_halted}, 24'h000000);
  endtask : t_shutdown
  task automatic t_link;
    edge_cnt = 0;
    link_go <= 1'b1;
    @(posedge i_core_clk);
    link_go <= 1'b0;
    repeat (90) @(posedge i_core_clk);
    chk(24'(edge_cnt), 24'h000006);
  endtask : t_link
  ////////////////////////////////////////////////////////////////
  // Main sequence: reset, wait out the default fill, then the scenarios
  initial begin
    {i_reset_n, i_wr, i_rd, gappy, link_go} = '0;
    i_addr = 4'h0;
    i_wdata = 24'h000000;
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (300) @(posedge i_core_clk);
    t_defaults();
    t_safeload();
    t_shutdown();
    t_link();
    tally_and_finish();
  end
endmodule : test_psu_safeload
`default_nettype wire

// ### rtl/psu_map.svh
// Offsets, field positions, reset values and timing counts of the parameter update block
`ifndef PSU_MAP_SVH
`define PSU_MAP_SVH
// Register addresses on the plain register port
`define PSU_ADDR_CTRL0 4'h0
`define PSU_ADDR_CTRL1 4'h1
`define PSU_ADDR_CTRL2 4'h2
`define PSU_ADDR_HOLD_ADDR0 4'h4
`define PSU_ADDR_HOLD_DATA0 4'h9
`define PSU_ADDR_PRAM_ADDR 4'hE
`define PSU_ADDR_PRAM_DATA 4'hF
// Field positions
`define PSU_BIT_SHUTDOWN 10
`define PSU_BIT_XFER_REQ 0
`define PSU_BIT_XFER_DONE 0
`define PSU_BIT_SHUT_DONE 1
`define PSU_BIT_FAST_RAMP 9
// Parameter RAM geometry
`define PSU_PRAM_DEPTH 256
`define PSU_PRAM_AW 8
`define PSU_PRAM_DW 22
`define PSU_HOLD_COUNT 5
`define PSU_IDLE_CYCLES 5
// Default values in 2.20 fractional form
`define PSU_ONE 22'h100000
`define PSU_HALF 22'h080000
`define PSU_SPREAD_FREQ 22'h01CD98
`define PSU_DECAY 22'h011D20
`define PSU_UNITY_LAST 8'hB3
`define PSU_BIQUAD_LAST 8'h6C
// Parameter RAM locations with their own power-up value or format
`define PSU_PA_LUT_FIRST 8'h6E
`define PSU_PA_MAIN_ATTACK 8'h8F
`define PSU_PA_SUB_ATTACK 8'hB2
`define PSU_PA_SPREAD_FREQ 8'hBA
`define PSU_PA_SUB_GAIN_L 8'hBD
`define PSU_PA_SUB_GAIN_R 8'hBE
`define PSU_PA_HOLD_MAIN 8'hBF
`define PSU_PA_HOLD_SUB 8'hC0
`define PSU_PA_DECAY_MAIN 8'hC1
`define PSU_PA_DECAY_SUB 8'hC2
`define PSU_HOLD_MAX 22'h000FFF
// Audio frame length in core cycles
`define PSU_FRAME_CYCLES 2048
// Volume ramp: least 10 ms, longest 20 ms; the ramp aims at 15 ms
`define PSU_RAMP_MS 15
`define PSU_CLK_MHZ 100
`define PSU_VOL_MAX 16'hFFFF
`endif

// ### rtl/psu_pkg.sv
// Types shared by the parameter update block
`default_nettype none
package psu_pkg;
  typedef enum logic [2:0] {
    PSU_RUN = 3'b000,
    PSU_RAMP_DOWN = 3'b001,
    PSU_HALTED = 3'b010,
    PSU_RAMP_UP = 3'b011
  } psu_core_e;

  typedef enum logic [1:0] {
    PSU_XF_IDLE = 2'b00,
    PSU_XF_WAIT = 2'b01,
    PSU_XF_WRITE = 2'b10
  } psu_xfer_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } psu_bus_s;
endpackage : psu_pkg
`default_nettype wire

// ### rtl/psu_safeload.sv
// Parameter RAM safe-update, soft shutdown ramps and parameter RAM defaults
`include "psu_map.svh"
`default_nettype none
module psu_safeload #(
  parameter int HOLDS = `PSU_HOLD_COUNT,
  parameter int IDLE_CYCLES = `PSU_IDLE_CYCLES,
  parameter int RAMP_CYCLES = `PSU_RAMP_MS * `PSU_CLK_MHZ * 1000,
  parameter int FRAME_CYCLES = `PSU_FRAME_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [23:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [23:0] o_rdata,
  // Program sequencer: parameter RAM idle in this instruction cycle, frame start
  input wire logic i_pram_idle,
  input wire logic i_frame_start,
  // Link clock from the serial port, only sampled here
  input wire logic i_link_clk,
  // Status to the core
  output logic o_core_halted,
  output logic [15:0] o_volume,
  output logic o_link_edge
);
  // Volume moves one step every RAMP_DIV cycles, so long ramps keep their length with unit steps
  localparam int RAMP_DIV = (RAMP_CYCLES / `PSU_VOL_MAX > 1) ? RAMP_CYCLES / `PSU_VOL_MAX : 1;
  localparam int RAMP_STEP = (`PSU_VOL_MAX * RAMP_DIV + RAMP_CYCLES - 1) / RAMP_CYCLES;

  // Idle counter is three bits wide and the ramp arithmetic must stay inside 32 bits
  if (HOLDS < 1 || HOLDS > 5 || IDLE_CYCLES < HOLDS || IDLE_CYCLES > 8 || RAMP_CYCLES < 1 ||
      RAMP_CYCLES > 30000000 || FRAME_CYCLES < 8) begin : g_bad_params
    $error("psu_safeload: unsupported parameter values");
  end

  // Power-up value of one parameter word
  function automatic logic [21:0] pram_default(input logic [7:0] a);
    logic [21:0] v;
    v = 22'h000000;
    if (a <= `PSU_BIQUAD_LAST && (a % 8'h05) == 8'h00) begin
      v = `PSU_ONE;
    end
    if (a >= `PSU_PA_LUT_FIRST && a <= `PSU_UNITY_LAST && a != `PSU_PA_MAIN_ATTACK && a != `PSU_PA_SUB_ATTACK) begin
      v = `PSU_ONE;
    end
    if (a == `PSU_PA_SUB_GAIN_L || a == `PSU_PA_SUB_GAIN_R) begin
      v = `PSU_HALF;
    end
    if (a == `PSU_PA_SPREAD_FREQ) begin
      v = `PSU_SPREAD_FREQ;
    end
    if (a == `PSU_PA_DECAY_MAIN || a == `PSU_PA_DECAY_SUB) begin
      v = `PSU_DECAY;
    end
    // 180 to 185, 187, 188, 191, 192 stay zero
    return v;
  endfunction : pram_default

  // Hold times stored as integers, clipped to 4095 samples
  function automatic logic [21:0] pram_format(input logic [7:0] a, input logic [21:0] d);
    logic [21:0] v;
    v = d;
    if ((a == `PSU_PA_HOLD_MAIN || a == `PSU_PA_HOLD_SUB) && d > `PSU_HOLD_MAX) begin
      v = `PSU_HOLD_MAX;
    end
    return v;
  endfunction : pram_format

  // Host write strobe aimed at holding register k, address or data half
  function automatic logic hold_hit(input logic wr, input logic [3:0] a, input int k);
    return wr && (a == `PSU_ADDR_HOLD_ADDR0 + 4'(k) || a == `PSU_ADDR_HOLD_DATA0 + 4'(k));
  endfunction : hold_hit

  typedef struct packed {
    psu_pkg::psu_core_e core;
    psu_pkg::psu_xfer_e xfer;
    logic shutdown;
    logic fast_ramp;
    logic [11:0] ctrl0;
    logic [9:0] ctrl2;
    logic xfer_done;
    logic shut_done;
    logic [HOLDS-1:0] pending;
    logic [2:0] idle_cnt;
    logic [2:0] wr_idx;
    logic [15:0] volume;
    logic [7:0] pram_ptr;
    logic [23:0] rdata;
    logic [2:0] link_sync;
    logic link_level;
    logic link_edge;
    logic init_busy;
    logic [7:0] init_ptr;
    logic halted;
    logic [23:0] ramp_tick;
  } psu_state_s;

  psu_state_s st;
  psu_state_s next_st;
  logic [7:0] hold_addr [HOLDS];
  logic [21:0] hold_data [HOLDS];
  logic [21:0] pram [`PSU_PRAM_DEPTH];
  logic pram_we;
  logic [7:0] pram_wa;
  logic [21:0] pram_wd;
  logic [21:0] pram_q;
  logic ramp_go;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    pram_we = 1'b0;
    pram_wa = 8'h00;
    pram_wd = 22'h000000;
    next_st.rdata = 24'h000000;
    // Three-flop sampler of the link clock; a level counts once stages two and three agree
    next_st.link_sync = {st.link_sync[1:0], i_link_clk};
    next_st.link_edge = 1'b0;
    if (st.link_sync[1] == st.link_sync[2]) begin
      next_st.link_level = st.link_sync[2];
      next_st.link_edge = st.link_sync[2] & ~st.link_level;
    end
    // Boot-time fill of the parameter RAM with the default program
    if (st.init_busy) begin
      pram_we = 1'b1;
      pram_wa = st.init_ptr;
      pram_wd = pram_default(st.init_ptr);
      next_st.init_ptr = st.init_ptr + 8'h01;
      next_st.init_busy = (st.init_ptr != 8'hFF);
    end
    // Register writes
    if (i_wr) begin
      case (i_addr)
        `PSU_ADDR_CTRL0: begin
          next_st.ctrl0 = i_wdata[11:0];
          next_st.shutdown = i_wdata[`PSU_BIT_SHUTDOWN];
        end
        `PSU_ADDR_CTRL1: begin
          if (i_wdata[`PSU_BIT_XFER_REQ] && st.xfer == psu_pkg::PSU_XF_IDLE) begin
            next_st.xfer = psu_pkg::PSU_XF_WAIT;
            next_st.idle_cnt = 3'h0;
          end
        end
        `PSU_ADDR_CTRL2: begin
          next_st.ctrl2 = i_wdata[9:0];
          next_st.fast_ramp = i_wdata[`PSU_BIT_FAST_RAMP];
        end
        `PSU_ADDR_PRAM_ADDR: next_st.pram_ptr = i_wdata[7:0];
        `PSU_ADDR_PRAM_DATA: begin
          // Direct write, glitch-free only while the core is halted
          if (!st.init_busy) begin
            pram_we = 1'b1;
            pram_wa = st.pram_ptr;
            pram_wd = pram_format(st.pram_ptr, i_wdata[21:0]);
          end
        end
        default: begin
        end
      endcase
      for (int k = 0; k < HOLDS; k++) begin
        if (hold_hit(i_wr, i_addr, k)) begin
          next_st.pending[k] = 1'b1;
        end
      end
    end
    // Register reads; read data stands in the following cycle only
    if (i_rd) begin
      case (i_addr)
        `PSU_ADDR_CTRL0: next_st.rdata = {12'h000, st.ctrl0};
        `PSU_ADDR_CTRL1: begin
          next_st.rdata = {22'h000000, st.shut_done, st.xfer_done};
          next_st.xfer_done = 1'b0;
        end
        `PSU_ADDR_CTRL2: next_st.rdata = {14'h0000, st.ctrl2};
        `PSU_ADDR_PRAM_ADDR: next_st.rdata = {16'h0000, st.pram_ptr};
        `PSU_ADDR_PRAM_DATA: next_st.rdata = {2'b00, pram_q};
        default: begin
          for (int k = 0; k < HOLDS; k++) begin
            if (i_addr == `PSU_ADDR_HOLD_ADDR0 + 4'(k)) begin
              next_st.rdata = {16'h0000, hold_addr[k]};
            end
            if (i_addr == `PSU_ADDR_HOLD_DATA0 + 4'(k)) begin
              next_st.rdata = {2'b00, hold_data[k]};
            end
          end
        end
      endcase
    end
    // Safe transfer: count idle cycles, then write pending holds one per cycle
    case (st.xfer)
      psu_pkg::PSU_XF_IDLE: begin
      end
      psu_pkg::PSU_XF_WAIT: begin
        if (st.init_busy) begin
          next_st.idle_cnt = 3'h0;
        end else if (i_pram_idle || st.core == psu_pkg::PSU_HALTED) begin
          next_st.idle_cnt = st.idle_cnt + 3'h1;
          if (st.idle_cnt == 3'(IDLE_CYCLES - 1)) begin
            next_st.xfer = psu_pkg::PSU_XF_WRITE;
            next_st.wr_idx = 3'h0;
          end
        end else begin
          next_st.idle_cnt = 3'h0;
        end
      end
      psu_pkg::PSU_XF_WRITE: begin
        // The window holds five idle cycles, enough for all five holds
        for (int k = 0; k < HOLDS; k++) begin
          if (st.wr_idx == 3'(k) && st.pending[k]) begin
            pram_we = 1'b1;
            pram_wa = hold_addr[k];
            pram_wd = pram_format(hold_addr[k], hold_data[k]);
            // A host write in the same cycle keeps the hold pending: the set wins
            if (!hold_hit(i_wr, i_addr, k)) begin
              next_st.pending[k] = 1'b0;
            end
          end
        end
        next_st.wr_idx = st.wr_idx + 3'h1;
        if (st.wr_idx == 3'(HOLDS - 1)) begin
          next_st.xfer = psu_pkg::PSU_XF_IDLE;
          next_st.xfer_done = 1'b1;
        end
      end
      default: next_st.xfer = psu_pkg::PSU_XF_IDLE;
    endcase
    // Ramp prescaler: rests at zero outside the ramps so each ramp starts aligned
    ramp_go = (st.ramp_tick == 24'(RAMP_DIV - 1));
    if (ramp_go || st.core == psu_pkg::PSU_RUN || st.core == psu_pkg::PSU_HALTED) begin
      next_st.ramp_tick = 24'h000000;
    end else begin
      next_st.ramp_tick = st.ramp_tick + 24'h000001;
    end
    // Soft shutdown and restart with volume ramps
    case (st.core)
      psu_pkg::PSU_RUN: begin
        if (st.shutdown) begin
          next_st.core = psu_pkg::PSU_RAMP_DOWN;
        end
      end
      psu_pkg::PSU_RAMP_DOWN: begin
        if (ramp_go && st.volume <= 16'(RAMP_STEP)) begin
          next_st.volume = 16'h0000;
          next_st.core = psu_pkg::PSU_HALTED;
          next_st.shut_done = 1'b1;
        end else if (ramp_go) begin
          next_st.volume = st.volume - 16'(RAMP_STEP);
        end
      end
      psu_pkg::PSU_HALTED: begin
        if (!st.shutdown) begin
          next_st.core = psu_pkg::PSU_RAMP_UP;
          next_st.shut_done = 1'b0;
        end
      end
      psu_pkg::PSU_RAMP_UP: begin
        if (ramp_go && st.volume >= 16'(`PSU_VOL_MAX - RAMP_STEP)) begin
          next_st.volume = `PSU_VOL_MAX;
          next_st.core = psu_pkg::PSU_RUN;
        end else if (ramp_go) begin
          next_st.volume = st.volume + 16'(RAMP_STEP);
        end
      end
      default: next_st.core = psu_pkg::PSU_RUN;
    endcase
    // Halt status registered so the output comes from a flip-flop
    next_st.halted = (next_st.core == psu_pkg::PSU_HALTED);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.volume <= `PSU_VOL_MAX;
      st.init_busy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Holding registers and parameter RAM carry data only, no reset needed
  always_ff @(posedge i_core_clk) begin
    for (int k = 0; k < HOLDS; k++) begin
      if (i_wr && i_addr == `PSU_ADDR_HOLD_ADDR0 + 4'(k)) begin
        hold_addr[k] <= i_wdata[7:0];
      end
      if (i_wr && i_addr == `PSU_ADDR_HOLD_DATA0 + 4'(k)) begin
        hold_data[k] <= i_wdata[21:0];
      end
    end
    if (pram_we) begin
      pram[pram_wa] <= pram_wd;
    end
  end

  assign pram_q = pram[st.pram_ptr];

  // Outputs straight from the state register
  assign o_rdata = st.rdata;
  assign o_core_halted = st.halted;
  assign o_volume = st.volume;
  assign o_link_edge = st.link_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_done_after_write;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (st.xfer == psu_pkg::PSU_XF_WRITE && st.wr_idx == 3'(HOLDS - 1)) |=> st.xfer_done;
  endproperty
  a_done_after_write: assert property (p_done_after_write) else $error("done flag not set");

  property p_read_clears;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == `PSU_ADDR_CTRL1 && st.xfer_done && st.xfer != psu_pkg::PSU_XF_WRITE)
        |=> (!st.xfer_done && o_rdata[0]);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("done flag not cleared by read");

  property p_idle_window;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      $rose(st.xfer == psu_pkg::PSU_XF_WRITE) |-> $past(st.idle_cnt) == 3'(IDLE_CYCLES - 1);
  endproperty
  a_idle_window: assert property (p_idle_window) else $error("write began early");

  property p_write_len;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      $rose(st.xfer == psu_pkg::PSU_XF_WRITE) |-> (st.xfer == psu_pkg::PSU_XF_WRITE) [*5] ##1 st.xfer_done;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write phase wrong length");

  property p_pending_cleared;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (st.xfer == psu_pkg::PSU_XF_WRITE && st.wr_idx == 3'h0 && st.pending[0] && !i_wr) |=> !st.pending[0];
  endproperty
  a_pending_cleared: assert property (p_pending_cleared) else $error("pending not cleared");

  property p_halt_flag;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      $rose(st.core == psu_pkg::PSU_HALTED) |-> st.shut_done && st.volume == 16'h0000;
  endproperty
  a_halt_flag: assert property (p_halt_flag) else $error("halt without done or volume");

  property p_ramp_up;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (st.core == psu_pkg::PSU_HALTED && !st.shutdown) |=> st.core == psu_pkg::PSU_RAMP_UP;
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("no restart ramp");

  property p_hold_store;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_wr && i_addr == `PSU_ADDR_HOLD_DATA0) |=> (hold_data[0] == $past(i_wdata[21:0]) && st.pending[0]);
  endproperty
  a_hold_store: assert property (p_hold_store) else $error("hold not captured");

  c_transfer: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) $rose(st.xfer_done));
  c_shutdown: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) $rose(o_core_halted));
  c_restart: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    st.core == psu_pkg::PSU_RAMP_UP ##1 st.core == psu_pkg::PSU_RUN);
endmodule : psu_safeload
`default_nettype wire
